// ---- pin_override.sv ----
/*
 * Alternate function override for port C and port D pads.
 * Assumes the port registers and peripherals sit on the same clock and
 * that the pad inputs are asynchronous.
 */
`timescale 1ns/1ns
`include "pin_override_cfg.svh"
module pin_override #(
    parameter int FILTER_CYCLES = `SPIKE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [6:0] portc_output,
    input wire logic [6:0] portc_direction,
    input wire logic [7:0] portd_output,
    input wire logic [7:0] portd_direction,
    input wire logic global_pullup_disable,
    input wire logic input_sleep_disable,
    input wire logic reset_pin_disable_fuse,
    input wire logic two_wire_enable,
    input wire logic scl_line_out,
    input wire logic sda_line_out,
    input wire logic usart_sync_select,
    input wire logic usart_clock_out,
    input wire logic transmitter_enable,
    input wire logic transmit_data,
    input wire logic receiver_enable,
    input wire logic ext_irq0_enable,
    input wire logic ext_irq1_enable,
    input wire logic [6:0] portc_pad_in,
    input wire logic [7:0] portd_pad_in,
    output logic [6:0] portc_pad_out,
    output logic [6:0] portc_pad_oe,
    output logic [6:0] portc_pullup,
    output logic [7:0] portd_pad_out,
    output logic [7:0] portd_pad_oe,
    output logic [7:0] portd_pullup,
    output logic [7:0] portd_input_enable,
    output logic [6:0] portc_direction_read,
    output logic [6:0] portc_output_read,
    output logic [6:0] portc_pin_read,
    output logic [7:0] portd_pin_read,
    output logic reset_pin_level,
    output logic two_wire_scl_in,
    output logic two_wire_sda_in,
    output logic two_wire_slew_limit,
    output logic [5:0] adc_pin_level,
    output logic usart_ext_clock,
    output logic timer0_count_input,
    output logic timer1_count_input,
    output logic ext_irq0_input,
    output logic ext_irq1_input,
    output logic receive_data_in
);

    // The filter counter is two bits wide, so longer filters cannot be served.
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 3)
    begin : g_bad_filter
        $error("FILTER_CYCLES must lie between 1 and 3");
    end

    pin_override_pkg::state_s s;
    pin_override_pkg::state_s next_s;

    // ----------------------------------------------------------------
    // Override logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [1:0] cnt;
        logic raw;
        cnt = 2'h0;
        raw = 1'b0;
        next_s = s;
        next_s.sync1_c = portc_pad_in;
        next_s.sync2_c = s.sync1_c;
        next_s.sync1_d = portd_pad_in;
        next_s.sync2_d = s.sync1_d;
        for (int i = 0; i < 7; i++)
        begin
            // Plain port behaviour; C3 to C0 never leave it.
            next_s.c_out[i] = portc_output[i];
            next_s.c_oe[i] = portc_direction[i];
            next_s.c_pu[i] = portc_output[i] & ~portc_direction[i] & ~global_pullup_disable;
            next_s.c_ie[i] = ~input_sleep_disable;
        end
        for (int i = 0; i < 8; i++)
        begin
            next_s.d_out[i] = portd_output[i];
            next_s.d_oe[i] = portd_direction[i];
            next_s.d_pu[i] = portd_output[i] & ~portd_direction[i] & ~global_pullup_disable;
            next_s.d_ie[i] = ~input_sleep_disable;
        end
        if (!reset_pin_disable_fuse)
        begin
            // Pin belongs to the reset circuit.
            next_s.c_out[`RESET_PIN] = 1'b0;
            next_s.c_oe[`RESET_PIN] = 1'b0;
            next_s.c_pu[`RESET_PIN] = 1'b1;
            next_s.c_ie[`RESET_PIN] = 1'b0;
        end
        if (two_wire_enable)
        begin
            // Open drain: a high line output pulls the pad low.
            next_s.c_out[`SCL_PIN] = 1'b0;
            next_s.c_out[`SDA_PIN] = 1'b0;
            next_s.c_oe[`SCL_PIN] = scl_line_out;
            next_s.c_oe[`SDA_PIN] = sda_line_out;
            next_s.c_pu[`SCL_PIN] = portc_output[`SCL_PIN] & ~global_pullup_disable;
            next_s.c_pu[`SDA_PIN] = portc_output[`SDA_PIN] & ~global_pullup_disable;
        end
        if (usart_sync_select)
            next_s.d_out[`XCK_PIN] = usart_clock_out;
        if (transmitter_enable)
        begin
            next_s.d_oe[`TXD_PIN] = 1'b1;
            next_s.d_out[`TXD_PIN] = transmit_data;
            next_s.d_pu[`TXD_PIN] = 1'b0;
        end
        if (receiver_enable)
        begin
            next_s.d_oe[`RXD_PIN] = 1'b0;
            next_s.d_pu[`RXD_PIN] = portd_output[`RXD_PIN] & ~global_pullup_disable;
        end
        // Interrupts must still see the pin while inputs sleep.
        if (ext_irq0_enable)
            next_s.d_ie[`IRQ0_PIN] = 1'b1;
        if (ext_irq1_enable)
            next_s.d_ie[`IRQ1_PIN] = 1'b1;

        // Spike filter: a level is taken only once it stood long enough.
        for (int k = 0; k < 2; k++)
        begin
            raw = s.sync2_c[`SDA_PIN + k];
            cnt = s.filt_cnt[2 * k +: 2];
            if (!two_wire_enable || FILTER_CYCLES == 1 || raw == s.filt_level[k])
            begin
                next_s.filt_level[k] = two_wire_enable ? raw : 1'b1;
                next_s.filt_cnt[2 * k +: 2] = 2'h0;
            end
            else if (32'(cnt) + 32'd1 >= FILTER_CYCLES)
            begin
                next_s.filt_level[k] = raw;
                next_s.filt_cnt[2 * k +: 2] = 2'h0;
            end
            else
                next_s.filt_cnt[2 * k +: 2] = cnt + 2'h1;
        end

        next_s.c_dir_rd = portc_direction;
        next_s.c_out_rd = portc_output;
        next_s.c_pin_rd = s.sync2_c & next_s.c_ie;
        if (!reset_pin_disable_fuse)
        begin
            next_s.c_dir_rd[`RESET_PIN] = 1'b0;
            next_s.c_out_rd[`RESET_PIN] = 1'b0;
            next_s.c_pin_rd[`RESET_PIN] = 1'b0;
        end
        next_s.d_pin_rd = s.sync2_d & next_s.d_ie;
        next_s.reset_level = s.sync2_c[`RESET_PIN] | reset_pin_disable_fuse;
        next_s.slew = two_wire_enable;
        next_s.adc_level = s.sync2_c[5:0];
        next_s.xck_in = s.sync2_d[`XCK_PIN];
        next_s.t0_in = s.sync2_d[`XCK_PIN];
        next_s.t1_in = s.sync2_d[`TIMER1_PIN];
        next_s.irq0_in = s.sync2_d[`IRQ0_PIN];
        next_s.irq1_in = s.sync2_d[`IRQ1_PIN];
        next_s.rxd_in = s.sync2_d[`RXD_PIN] | ~receiver_enable;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '0;
            s.filt_level <= `FILTER_IDLE;
        end
        else
            s <= next_s;
    end

    assign portc_pad_out = s.c_out;
    assign portc_pad_oe = s.c_oe;
    assign portc_pullup = s.c_pu;
    assign portd_pad_out = s.d_out;
    assign portd_pad_oe = s.d_oe;
    assign portd_pullup = s.d_pu;
    assign portd_input_enable = s.d_ie;
    assign portc_direction_read = s.c_dir_rd;
    assign portc_output_read = s.c_out_rd;
    assign portc_pin_read = s.c_pin_rd;
    assign portd_pin_read = s.d_pin_rd;
    assign reset_pin_level = s.reset_level;
    assign two_wire_scl_in = s.filt_level[1];
    assign two_wire_sda_in = s.filt_level[0];
    assign two_wire_slew_limit = s.slew;
    assign adc_pin_level = s.adc_level;
    assign usart_ext_clock = s.xck_in;
    assign timer0_count_input = s.t0_in;
    assign timer1_count_input = s.t1_in;
    assign ext_irq0_input = s.irq0_in;
    assign ext_irq1_input = s.irq1_in;
    assign receive_data_in = s.rxd_in;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_pin_io: assert property (
        !reset_pin_disable_fuse |=> !portc_pad_oe[6] && portc_pullup[6])
        else $error("reset pin driven as I/O");
    a_reset_pin_reads: assert property (
        !reset_pin_disable_fuse |=> portc_direction_read[6] == 1'b0
            && portc_output_read[6] == 1'b0 && portc_pin_read[6] == 1'b0)
        else $error("reset pin reads not zero");
    a_twi_open_drain: assert property (
        two_wire_enable |=> portc_pad_out[5:4] == 2'h0
            && portc_pad_oe[5] == $past(scl_line_out) && portc_pad_oe[4] == $past(sda_line_out))
        else $error("two-wire pins not open drain");
    a_spike_reject: assert property (
        two_wire_enable && $past(two_wire_enable) && $past(two_wire_enable, 2)
            && $past(two_wire_enable, 3) && $changed(two_wire_scl_in)
            |-> $past(s.sync2_c[5], 1) == $past(s.sync2_c[5], 2))
        else $error("clock spike passed filter");
    a_twi_slew: assert property (
        two_wire_enable |=> two_wire_slew_limit)
        else $error("slew control missing");
    a_twi_pullup: assert property (
        two_wire_enable |=> portc_pullup[4] == $past(portc_output[4] && !global_pullup_disable))
        else $error("two-wire pull-up wrong");
    a_txd_force: assert property (
        transmitter_enable |=> portd_pad_oe[1] && portd_pad_out[1] == $past(transmit_data))
        else $error("transmit pin not forced");
    a_rxd_input: assert property (
        receiver_enable |=> !portd_pad_oe[0]
            && portd_pullup[0] == $past(portd_output[0] && !global_pullup_disable))
        else $error("receive pin not forced input");
    a_xck_value: assert property (
        usart_sync_select |=> portd_pad_out[4] == $past(usart_clock_out))
        else $error("usart clock not on pin");
    a_timer1_plain: assert property (
        1'b1 |=> portd_pad_oe[5] == $past(portd_direction[5]) && portd_pullup[5]
            == $past(portd_output[5] && !portd_direction[5] && !global_pullup_disable))
        else $error("timer 1 pin overridden");
    a_irq_buffer_on: assert property (
        ext_irq0_enable ##1 ext_irq0_enable |=> portd_input_enable[2] && portd_input_enable[2]
            == 1'b1 && ext_irq0_input == $past(s.sync2_d[2], 1))
        else $error("interrupt input buffer off");
    a_adc_plain: assert property (
        1'b1 |=> portc_pad_oe[3:0] == $past(portc_direction[3:0])
            && portc_pad_out[3:0] == $past(portc_output[3:0]))
        else $error("converter pins overridden");

    c_twi_active: cover property (two_wire_enable && portc_pad_oe[5]);
    c_reset_mode: cover property (!reset_pin_disable_fuse ##1 reset_pin_disable_fuse);
    c_usart_full: cover property (transmitter_enable && receiver_enable && usart_sync_select);
    c_spike_seen: cover property (two_wire_enable && s.filt_cnt[3:2] != 2'h0);

endmodule

// ---- pin_override_cfg.svh ----
/*
 * Constants for the port C and port D override logic: pin positions,
 * reset values and the spike filter timing.
 * Assumes a single 25 MHz clock.
 */
`ifndef PIN_OVERRIDE_CFG_SVH
`define PIN_OVERRIDE_CFG_SVH

`define RESET_PIN 6
`define SCL_PIN 5
`define SDA_PIN 4
`define XCK_PIN 4
`define TIMER1_PIN 5
`define IRQ1_PIN 3
`define IRQ0_PIN 2
`define TXD_PIN 1
`define RXD_PIN 0
`define CLOCK_PERIOD_NS 40
`define SPIKE_NS 50
`define SPIKE_CYCLES ((`SPIKE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FILTER_IDLE 2'h3

`endif

// ---- pin_override_pkg.sv ----
/*
 * Types for the port C and port D override logic.
 * Assumes nothing beyond the configuration header.
 */
package pin_override_pkg;

    typedef struct packed {
        logic [6:0] sync1_c;
        logic [6:0] sync2_c;
        logic [7:0] sync1_d;
        logic [7:0] sync2_d;
        logic [1:0] filt_level;
        logic [3:0] filt_cnt;
        logic [6:0] c_out;
        logic [6:0] c_oe;
        logic [6:0] c_pu;
        logic [6:0] c_ie;
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic [7:0] d_pu;
        logic [7:0] d_ie;
        logic [6:0] c_dir_rd;
        logic [6:0] c_out_rd;
        logic [6:0] c_pin_rd;
        logic [7:0] d_pin_rd;
        logic reset_level;
        logic slew;
        logic [5:0] adc_level;
        logic xck_in;
        logic t0_in;
        logic t1_in;
        logic irq0_in;
        logic irq1_in;
        logic rxd_in;
    } state_s;

endpackage

// ---- pad_model.sv ----
/* Pad model for the port C and port D pins: resolves each pad from the
   block's drive and an outside driver that the bench controls.
   Assumes the block's clock; the float pattern steps on it. */
`timescale 1ns/1ns
module pad_model #(
    parameter logic [6:0] BUS_PULLUP = 7'h30
) (
    input wire logic clock,
    input wire logic [6:0] portc_pad_out,
    input wire logic [6:0] portc_pad_oe,
    input wire logic [6:0] portc_pullup,
    input wire logic [7:0] portd_pad_out,
    input wire logic [7:0] portd_pad_oe,
    input wire logic [7:0] portd_pullup,
    input wire logic [6:0] c_ext_en,
    input wire logic [6:0] c_ext_val,
    input wire logic [7:0] d_ext_en,
    input wire logic [7:0] d_ext_val,
    output logic [6:0] portc_pad_in,
    output logic [7:0] portd_pad_in
);
    logic flip = 1'b0;
    // An undriven pad toggles so that a stale level never passes for a real one.
    always @(posedge clock)
        flip <= ~flip;
    // Any low driver wins, as on an open-drain line with a bus pull-up.
    function automatic logic level(input logic oe, o, pu, en, v, f);
        if ((oe && !o) || (en && !v))
            return 1'b0;
        if ((oe && o) || (en && v) || pu)
            return 1'b1;
        return f;
    endfunction
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            portc_pad_in[i] = level(portc_pad_oe[i], portc_pad_out[i],
                portc_pullup[i] || BUS_PULLUP[i], c_ext_en[i], c_ext_val[i], flip);
        for (int i = 0; i < 8; i++)
            portd_pad_in[i] = level(portd_pad_oe[i], portd_pad_out[i],
                portd_pullup[i], d_ext_en[i], d_ext_val[i], flip);
    end
endmodule

// ---- pin_override_tb_top.sv ----
/* Self-checking bench for pin_override: drives port bits and peripheral
   controls and checks overrides and synchronised pad levels.
   Assumes pad_model resolves the pads and a 25 MHz clock. */
`timescale 1ns/1ns
module pin_override_tb_top;
    logic clock = 1'b0, rst = 1'b1;
    logic [6:0] portc_output = 7'h00, portc_direction = 7'h00;
    logic [7:0] portd_output = 8'h00, portd_direction = 8'h00;
    logic global_pullup_disable = 1'b0, input_sleep_disable = 1'b0;
    logic reset_pin_disable_fuse = 1'b0, two_wire_enable = 1'b0;
    logic scl_line_out = 1'b0, sda_line_out = 1'b0, usart_sync_select = 1'b0;
    logic usart_clock_out = 1'b0, transmitter_enable = 1'b0, transmit_data = 1'b0;
    logic receiver_enable = 1'b0, ext_irq0_enable = 1'b0, ext_irq1_enable = 1'b0;
    logic [6:0] c_ext_en = 7'h40, c_ext_val = 7'h40, portc_pad_in;
    logic [7:0] d_ext_en = 8'hfd, d_ext_val = 8'h00, portd_pad_in;
    logic [6:0] portc_pad_out, portc_pad_oe, portc_pullup;
    logic [6:0] portc_direction_read, portc_output_read, portc_pin_read;
    logic [7:0] portd_pad_out, portd_pad_oe, portd_pullup, portd_input_enable, portd_pin_read;
    logic reset_pin_level, two_wire_scl_in, two_wire_sda_in, two_wire_slew_limit;
    logic [5:0] adc_pin_level;
    logic usart_ext_clock, timer0_count_input, timer1_count_input;
    logic ext_irq0_input, ext_irq1_input, receive_data_in;
    int miscompares = 0, total_checks = 0;

    always #20 clock = ~clock;

    pin_override u_pin_override (.clock, .rst, .portc_output, .portc_direction,
        .portd_output, .portd_direction, .global_pullup_disable, .input_sleep_disable,
        .reset_pin_disable_fuse, .two_wire_enable, .scl_line_out, .sda_line_out,
        .usart_sync_select, .usart_clock_out, .transmitter_enable, .transmit_data,
        .receiver_enable, .ext_irq0_enable, .ext_irq1_enable, .portc_pad_in,
        .portd_pad_in, .portc_pad_out, .portc_pad_oe, .portc_pullup, .portd_pad_out,
        .portd_pad_oe, .portd_pullup, .portd_input_enable, .portc_direction_read,
        .portc_output_read, .portc_pin_read, .portd_pin_read, .reset_pin_level,
        .two_wire_scl_in, .two_wire_sda_in, .two_wire_slew_limit, .adc_pin_level,
        .usart_ext_clock, .timer0_count_input, .timer1_count_input, .ext_irq0_input,
        .ext_irq1_input, .receive_data_in);

    pad_model u_pad_model (.clock, .portc_pad_out, .portc_pad_oe, .portc_pullup,
        .portd_pad_out, .portd_pad_oe, .portd_pullup, .c_ext_en, .c_ext_val,
        .d_ext_en, .d_ext_val, .portc_pad_in, .portd_pad_in);

    task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_vec(name, {7'h00, exp}, {7'h00, got});
    endtask

    // Inputs change 1 ns after an edge; outputs are sampled at the same point.
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        miscompares++;
        summarize();
    end

    initial
    begin
        cyc(10);
        chk_bit("scl_rst", 1'b1, two_wire_scl_in);
        chk_vec("doe_rst", 8'h00, portd_pad_oe);
        rst = 1'b0;
        portc_direction = 7'h7f;
        portc_output = 7'h7f;
        // Pin readback needs the pads to settle and pass both synchroniser stages.
        cyc(4);
        chk_vec("cdir_rd", 8'h3f, {1'b0, portc_direction_read});
        chk_vec("cout_rd", 8'h3f, {1'b0, portc_output_read});
        chk_vec("cpin_rd", 8'h3f, {1'b0, portc_pin_read});
        chk_vec("coe", 8'h3f, {1'b0, portc_pad_oe});
        chk_bit("rst_lvl", 1'b1, reset_pin_level);
        c_ext_val = 7'h00;
        cyc(3);
        chk_bit("rst_lvl", 1'b0, reset_pin_level);
        reset_pin_disable_fuse = 1'b1;
        cyc(1);
        chk_vec("cdir_rd", 8'h7f, {1'b0, portc_direction_read});
        chk_vec("coe", 8'h7f, {1'b0, portc_pad_oe});
        portc_direction = 7'h05;
        portc_output = 7'h0f;
        cyc(3);
        chk_vec("coe", 8'h05, {1'b0, portc_pad_oe});
        chk_vec("cout", 8'h0f, {1'b0, portc_pad_out});
        chk_vec("cpu", 8'h0a, {1'b0, portc_pullup});
        chk_vec("adc", 8'h3f, {2'b00, adc_pin_level});
        global_pullup_disable = 1'b1;
        cyc(1);
        chk_vec("cpu", 8'h00, {1'b0, portc_pullup});
        global_pullup_disable = 1'b0;
        portc_direction = 7'h30;
        portc_output = 7'h30;
        two_wire_enable = 1'b1;
        scl_line_out = 1'b1;
        cyc(1);
        chk_vec("coe", 8'h20, {1'b0, portc_pad_oe});
        chk_vec("cout", 8'h00, {1'b0, portc_pad_out} & 8'h30);
        chk_vec("cpu", 8'h30, {1'b0, portc_pullup} & 8'h30);
        chk_bit("slew", 1'b1, two_wire_slew_limit);
        cyc(4);
        chk_bit("scl_in", 1'b0, two_wire_scl_in);
        chk_bit("sda_in", 1'b1, two_wire_sda_in);
        chk_vec("adc", 8'h10, {2'b00, adc_pin_level} & 8'h30);
        scl_line_out = 1'b0;
        global_pullup_disable = 1'b1;
        cyc(1);
        chk_vec("cpu", 8'h00, {1'b0, portc_pullup});
        cyc(5);
        chk_bit("scl_in", 1'b1, two_wire_scl_in);
        c_ext_en = 7'h50;
        cyc(1);
        c_ext_en = 7'h40;
        for (int k = 0; k < 8; k++)
        begin
            cyc(1);
            chk_bit("sda_spike", 1'b1, two_wire_sda_in);
        end
        c_ext_en = 7'h50;
        cyc(3);
        chk_bit("sda_in", 1'b1, two_wire_sda_in);
        cyc(1);
        chk_bit("sda_in", 1'b0, two_wire_sda_in);
        c_ext_en = 7'h40;
        two_wire_enable = 1'b0;
        cyc(1);
        chk_bit("slew", 1'b0, two_wire_slew_limit);
        chk_vec("coe", 8'h30, {1'b0, portc_pad_oe});
        for (int k = 0; k < 4; k++)
        begin
            d_ext_val = 8'h04 << k;
            cyc(3);
            chk_bit("irq0", k == 0, ext_irq0_input);
            chk_bit("irq1", k == 1, ext_irq1_input);
            chk_bit("xck", k == 2, usart_ext_clock);
            chk_bit("t0", k == 2, timer0_count_input);
            chk_bit("t1", k == 3, timer1_count_input);
            chk_vec("doe", 8'h00, portd_pad_oe);
            // D1 floats here, so its readback bit is left out.
            chk_vec("dpin", 8'h04 << k, portd_pin_read & 8'hfd);
        end
        d_ext_en = 8'hed;
        portd_direction = 8'h10;
        usart_sync_select = 1'b1;
        usart_clock_out = 1'b1;
        cyc(1);
        chk_bit("xck_out", 1'b1, portd_pad_out[4]);
        cyc(3);
        chk_bit("xck", 1'b1, usart_ext_clock);
        usart_sync_select = 1'b0;
        cyc(1);
        chk_bit("xck_out", 1'b0, portd_pad_out[4]);
        portd_direction = 8'h01;
        portd_output = 8'h01;
        global_pullup_disable = 1'b0;
        transmitter_enable = 1'b1;
        transmit_data = 1'b1;
        receiver_enable = 1'b1;
        d_ext_val = 8'h01;
        cyc(1);
        chk_vec("doe", 8'h02, portd_pad_oe);
        chk_bit("txd", 1'b1, portd_pad_out[1]);
        chk_bit("rx_pu", 1'b1, portd_pullup[0]);
        transmit_data = 1'b0;
        global_pullup_disable = 1'b1;
        cyc(1);
        chk_bit("txd", 1'b0, portd_pad_out[1]);
        chk_bit("rx_pu", 1'b0, portd_pullup[0]);
        cyc(1);
        chk_bit("rxd", 1'b1, receive_data_in);
        d_ext_val = 8'h00;
        cyc(3);
        chk_bit("rxd", 1'b0, receive_data_in);
        receiver_enable = 1'b0;
        transmitter_enable = 1'b0;
        cyc(1);
        chk_vec("doe", 8'h01, portd_pad_oe);
        input_sleep_disable = 1'b1;
        ext_irq0_enable = 1'b1;
        cyc(1);
        chk_vec("die", 8'h04, portd_input_enable);
        ext_irq1_enable = 1'b1;
        cyc(1);
        chk_vec("die", 8'h0c, portd_input_enable);
        input_sleep_disable = 1'b0;
        cyc(1);
        chk_vec("die", 8'hff, portd_input_enable);
        summarize();
    end
endmodule
